//--- rtl/tba_ahb_slave.sv
// AHB-Lite slave front end with zero wait states
`timescale 1ns/1ps
`default_nettype none
module tba_ahb_slave
  import tba_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Register side
  output logic      [7:0]  rdAddr,
  input  wire logic [31:0] rdData,
  output tba_wr_s          wrReq
);

  // ==========================================================================
  // Address phase capture
  logic       take;
  logic       wrPend_r;
  logic       wrPend_nxt;
  logic [7:0] wrAddr_r;
  logic [7:0] wrAddr_nxt;
  logic [31:0] hrdata_nxt;

  always_comb
  begin
    take       = hsel && hready && htrans[1] && (hsize == 3'h2);
    rdAddr     = haddr[7:0];
    wrPend_nxt = take && hwrite;
    wrAddr_nxt = take ? haddr[7:0] : wrAddr_r;
    hrdata_nxt = (take && !hwrite) ? rdData : hrdata;
    wrReq.en   = wrPend_r;
    wrReq.addr = wrAddr_r;
    wrReq.data = hwdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wrPend_r  <= 1'b0;
      wrAddr_r  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      wrPend_r  <= wrPend_nxt;
      wrAddr_r  <= wrAddr_nxt;
      hrdata    <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : tba_ahb_slave
`default_nettype wire

//--- rtl/tba_attrib.sv
// Type B attribute command interpreter with register access
`timescale 1ns/1ps
`default_nettype none
module tba_attrib
  import tba_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Received frame
  input  wire logic        rxByteValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxFrameEnd,
  input  wire logic        rxCrcOk,
  // Answer
  output logic             respValid_r,
  output logic      [7:0]  respByte_r,
  output logic             respSof_r,
  output logic             respEof_r,
  output logic      [1:0]  respTr0_r,
  output logic      [1:0]  respTr1_r,
  output logic      [1:0]  respRate_r,
  output logic             cmdActive_r
);

  // ==========================================================================
  // Register bus
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  tba_wr_s     wrReq;

  tba_ahb_slave u_slave (
    .core_clk  (core_clk),
    .srst      (srst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rdAddr    (rdAddr),
    .rdData    (rdData),
    .wrReq     (wrReq)
  );

  // ==========================================================================
  // State
  tba_state_e  state_r,     state_nxt;
  tba_frame_s  frame_r,     frame_nxt;
  logic [3:0]  cnt_r,       cnt_nxt;
  logic        enable_r,    enable_nxt;
  logic [31:0] pupi_r,      pupi_nxt;
  logic [31:0] param_r,     param_nxt;
  tba_drop_e   drop_r,      drop_nxt;
  logic        accepted_r,  accepted_nxt;
  logic [1:0]  reqTr0_r,    reqTr0_nxt;
  logic [1:0]  reqTr1_r,    reqTr1_nxt;
  logic        respValid_nxt;
  logic [1:0]  respRate_nxt;
  logic        deselect;
  logic        rateOk;
  logic        sizeOk;
  logic        good;
  tba_drop_e   verdict;

  // ==========================================================================
  // Frame checks
  always_comb
  begin
    rateOk  = (frame_r.p2[7:6] == frame_r.p2[5:4]) &&
              (frame_r.p2[7:6] == RATE_106 || frame_r.p2[7:6] == RATE_212);
    sizeOk  = (frame_r.p2[3:0] == FSZ_256) || (frame_r.p2[3:0] == FSZ_128) ||
              (frame_r.p2[3:0] == FSZ_96)  || (frame_r.p2[3:0] == FSZ_64);
    if (cnt_r != FRAME_LEN)
      verdict = DROP_LEN;
    else if (!rxCrcOk)
      verdict = DROP_CRC;
    else if (frame_r.code != ATTR_CMD_CODE)
      verdict = DROP_CODE;
    else if (frame_r.ident != pupi_r)
      verdict = DROP_ID;
    else if (!rateOk || !sizeOk)
      verdict = DROP_RATE;
    else if (frame_r.p3 != PARAM3_VALUE)
      verdict = DROP_PROTO;
    else if (frame_r.p4[3:0] != CID_NONE)
      verdict = DROP_CID;
    else
      verdict = DROP_NONE;
    good = enable_r && rxFrameEnd && (verdict == DROP_NONE);
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_nxt     = state_r;
    frame_nxt     = frame_r;
    cnt_nxt       = cnt_r;
    enable_nxt    = enable_r;
    pupi_nxt      = pupi_r;
    param_nxt     = param_r;
    drop_nxt      = drop_r;
    accepted_nxt  = accepted_r;
    reqTr0_nxt    = reqTr0_r;
    reqTr1_nxt    = reqTr1_r;
    respValid_nxt = 1'b0;
    respRate_nxt  = respRate_r;
    deselect      = wrReq.en && (wrReq.addr == ADDR_CTRL) && wrReq.data[CTRL_DESEL_BIT];

    // Software writes
    if (wrReq.en && wrReq.addr == ADDR_CTRL)
      enable_nxt = wrReq.data[CTRL_EN_BIT];
    if (wrReq.en && wrReq.addr == ADDR_PUPI)
      pupi_nxt = wrReq.data;
    if (deselect)
      state_nxt = ST_IDLE;

    // Byte collection, the frame end takes priority over a byte
    if (rxFrameEnd)
      cnt_nxt = 4'h0;
    else if (rxByteValid && enable_r && cnt_r != FRAME_OVER)
    begin
      cnt_nxt = cnt_r + 4'h1;
      case (cnt_r)
        4'h0:    frame_nxt.code          = rxByte;
        4'h1:    frame_nxt.ident[31:24]  = rxByte;
        4'h2:    frame_nxt.ident[23:16]  = rxByte;
        4'h3:    frame_nxt.ident[15:8]   = rxByte;
        4'h4:    frame_nxt.ident[7:0]    = rxByte;
        4'h5:    frame_nxt.p1            = rxByte;
        4'h6:    frame_nxt.p2            = rxByte;
        4'h7:    frame_nxt.p3            = rxByte;
        4'h8:    frame_nxt.p4            = rxByte;
        default: frame_nxt               = frame_r;
      endcase
    end

    // Evaluation at frame end; silent frames leave state untouched
    if (rxFrameEnd && enable_r)
    begin
      drop_nxt     = verdict;
      accepted_nxt = good;
      if (good)
      begin
        respValid_nxt = 1'b1;
        state_nxt     = ST_ACTIVE;
        respRate_nxt  = frame_r.p2[7:6];
        param_nxt     = {frame_r.p1, frame_r.p2, frame_r.p3, frame_r.p4};
        reqTr0_nxt    = (frame_r.p1[7:6] == TIME_RFU) ? TR0_64FS : frame_r.p1[7:6];
        reqTr1_nxt    = (frame_r.p1[5:4] == TIME_RFU) ? TR1_80FS : frame_r.p1[5:4];
      end
    end
  end

  // ==========================================================================
  // Register read mux
  always_comb
  begin
    case (rdAddr)
      ADDR_CTRL:   rdData = {31'h0000_0000, enable_r};
      ADDR_PUPI:   rdData = pupi_r;
      ADDR_STATUS: rdData = {12'h000, PROTO_TYPE, 2'h0, respRate_r, reqTr1_r, reqTr0_r,
                             3'h0, drop_r, accepted_r, state_r};
      ADDR_PARAM:  rdData = param_r;
      default:     rdData = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r     <= ST_IDLE;
      frame_r     <= '0;
      cnt_r       <= 4'h0;
      enable_r    <= CTRL_EN_RST;
      pupi_r      <= PUPI_RST;
      param_r     <= 32'h0000_0000;
      drop_r      <= DROP_NONE;
      accepted_r  <= 1'b0;
      reqTr0_r    <= TR0_64FS;
      reqTr1_r    <= TR1_80FS;
      respValid_r <= 1'b0;
      respByte_r  <= ANSWER_BYTE;
      respSof_r   <= 1'b1;
      respEof_r   <= 1'b1;
      respTr0_r   <= TR0_64FS;
      respTr1_r   <= TR1_80FS;
      respRate_r  <= RATE_106;
      cmdActive_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      frame_r     <= frame_nxt;
      cnt_r       <= cnt_nxt;
      enable_r    <= enable_nxt;
      pupi_r      <= pupi_nxt;
      param_r     <= param_nxt;
      drop_r      <= drop_nxt;
      accepted_r  <= accepted_nxt;
      reqTr0_r    <= reqTr0_nxt;
      reqTr1_r    <= reqTr1_nxt;
      respValid_r <= respValid_nxt;
      respByte_r  <= ANSWER_BYTE;
      respSof_r   <= 1'b1;
      respEof_r   <= 1'b1;
      respTr0_r   <= TR0_64FS;
      respTr1_r   <= TR1_80FS;
      respRate_r  <= respRate_nxt;
      cmdActive_r <= (state_nxt == ST_ACTIVE);
    end
  end

  // ==========================================================================
  // Assertions
  sequence goodEnd_s;
    enable_r && rxFrameEnd && cnt_r == FRAME_LEN && rxCrcOk &&
    frame_r.code == ATTR_CMD_CODE && frame_r.ident == pupi_r && rateOk && sizeOk &&
    frame_r.p3 == PARAM3_VALUE && frame_r.p4[3:0] == 4'h0;
  endsequence

  sequence answered_s;
    respValid_r && respByte_r == 8'h10 ##0 cmdActive_r;
  endsequence

  accept_answer_a: assert property (@(posedge core_clk) disable iff (srst)
    goodEnd_s |=> answered_s)
    else $error("Valid command not answered with 0x10");

  answer_cause_a: assert property (@(posedge core_clk) disable iff (srst)
    respValid_r |-> $past(good) && cmdActive_r && state_r == ST_ACTIVE)
    else $error("Answer without accepted command or activation");

  rate_mismatch_a: assert property (@(posedge core_clk) disable iff (srst)
    rxFrameEnd && frame_r.p2[7:6] != frame_r.p2[5:4] |=> !respValid_r)
    else $error("Answer despite unequal data rates");

  frame_size_a: assert property (@(posedge core_clk) disable iff (srst)
    rxFrameEnd && !(frame_r.p2[3:0] inside {4'h5, 4'h6, 4'h7, 4'h8}) |=> !respValid_r)
    else $error("Answer despite unsupported frame size");

  proto_check_a: assert property (@(posedge core_clk) disable iff (srst)
    rxFrameEnd && frame_r.p3 != 8'h01 |=> !respValid_r)
    else $error("Answer despite bad protocol parameter");

  cid_check_a: assert property (@(posedge core_clk) disable iff (srst)
    rxFrameEnd && frame_r.p4[3:0] != 4'h0 |=> !respValid_r)
    else $error("Answer despite nonzero CID");

  id_crc_a: assert property (@(posedge core_clk) disable iff (srst)
    rxFrameEnd && (!rxCrcOk || frame_r.ident != pupi_r) && !deselect
    |=> !respValid_r && $stable(cmdActive_r))
    else $error("Mismatched identifier or CRC changed state");

  silent_keep_a: assert property (@(posedge core_clk) disable iff (srst)
    !good && !deselect |=> $stable(cmdActive_r))
    else $error("Silent command changed state");

  sof_eof_a: assert property (@(posedge core_clk) disable iff (srst)
    respValid_r |-> respSof_r && respEof_r)
    else $error("SOF or EOF omitted");

  min_times_a: assert property (@(posedge core_clk) disable iff (srst)
    respValid_r |-> respTr0_r == 2'h0 && respTr1_r == 2'h0 &&
      (reqTr0_r != 2'h3) && (reqTr1_r != 2'h3))
    else $error("Minimum response times not kept");

endmodule : tba_attrib
`default_nettype wire

//--- rtl/tba_pkg.sv
// Constants, types and register map of the Type B attribute command block
package tba_pkg;

  // ==========================================================================
  // Command and answer framing
  localparam logic [7:0] ATTR_CMD_CODE = 8'h1D;
  localparam logic [3:0] FRAME_LEN     = 4'hB;
  localparam logic [3:0] FRAME_OVER    = 4'hC;
  localparam logic [3:0] MBLI_VALUE    = 4'h1;
  localparam logic [3:0] CID_NONE      = 4'h0;
  localparam logic [7:0] ANSWER_BYTE   = {MBLI_VALUE, CID_NONE};
  localparam logic [3:0] PROTO_TYPE    = 4'h1;
  localparam logic [7:0] PARAM3_VALUE  = {4'h0, PROTO_TYPE};

  // ==========================================================================
  // Parameter field codes
  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [1:0] TIME_RFU = 2'h3;
  localparam logic [1:0] TR0_64FS = 2'h0;
  localparam logic [1:0] TR1_80FS = 2'h0;
  localparam logic [3:0] FSZ_256  = 4'h8;
  localparam logic [3:0] FSZ_128  = 4'h7;
  localparam logic [3:0] FSZ_96   = 4'h6;
  localparam logic [3:0] FSZ_64   = 4'h5;

  // ==========================================================================
  // Register map
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_PUPI      = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_PARAM     = 8'h0C;
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_DESEL_BIT = 1;
  localparam logic        CTRL_EN_RST    = 1'b1;
  localparam logic [31:0] PUPI_RST       = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_ACTIVE = 1'b1
  } tba_state_e;

  typedef enum logic [2:0] {
    DROP_NONE  = 3'b000,
    DROP_LEN   = 3'b001,
    DROP_CRC   = 3'b010,
    DROP_CODE  = 3'b011,
    DROP_ID    = 3'b100,
    DROP_RATE  = 3'b101,
    DROP_PROTO = 3'b110,
    DROP_CID   = 3'b111
  } tba_drop_e;

  typedef struct packed {
    logic [7:0]  code;
    logic [31:0] ident;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [7:0]  p3;
    logic [7:0]  p4;
  } tba_frame_s;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
  } tba_wr_s;

endpackage : tba_pkg

//--- verification/tba_reader_model.sv
// Reader side model that sends attribute command frames to the tag
`timescale 1ns/1ps
`default_nettype none
module tba_reader_model
  import tba_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Frame link
  output logic            rxByteValid,
  output logic      [7:0] rxByte,
  output logic            rxFrameEnd,
  output logic            rxCrcOk
);
  logic busy;

  initial
  begin
    rxByteValid = 1'b0;
    rxByte      = 8'h00;
    rxFrameEnd  = 1'b0;
    rxCrcOk     = 1'b0;
    busy        = 1'b0;
  end

  // ==========================================================================
  // Idle byte lane toggles so no stale byte is seen
  always @(posedge core_clk)
  begin
    if (!busy)
      rxByte <= ~rxByte;
  end

  // ==========================================================================
  // Frame sender: code, identifier, four parameters, two check bytes
  task automatic send(input tba_frame_s f, input logic crcOk, input int nBytes);
    logic [87:0] bytes;
    bytes = {f, 16'hA55A};
    busy = 1'b1;
    for (int i = 0; i < nBytes; i++)
    begin
      @(posedge core_clk);
      rxByteValid <= 1'b1;
      rxByte      <= bytes[87 - 8 * i -: 8];
    end
    @(posedge core_clk);
    rxByteValid <= 1'b0;
    rxFrameEnd  <= 1'b1;
    rxCrcOk     <= crcOk;
    @(posedge core_clk);
    rxFrameEnd <= 1'b0;
    rxCrcOk    <= ~crcOk;
    busy = 1'b0;
  endtask : send
endmodule : tba_reader_model
`default_nettype wire

//--- verification/type_b_attribute_command_tb.sv
// Self-checking bench for the Type B attribute command block
`timescale 1ns/1ps
`default_nettype none
module type_b_attribute_command_tb;
  import tba_pkg::*;

  localparam logic [31:0] TAG_ID = 32'h1234_5678;

  logic        core_clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rxByteValid;
  logic [7:0]  rxByte;
  logic        rxFrameEnd;
  logic        rxCrcOk;
  logic        respValid_r;
  logic [7:0]  respByte_r;
  logic        respSof_r;
  logic        respEof_r;
  logic [1:0]  respTr0_r;
  logic [1:0]  respTr1_r;
  logic [1:0]  respRate_r;
  logic        cmdActive_r;
  logic [31:0] rd;
  int          nErrors;
  int          cmpCount;
  int          cyc;

  tba_attrib DUT (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd),
    .rxCrcOk(rxCrcOk), .respValid_r(respValid_r), .respByte_r(respByte_r),
    .respSof_r(respSof_r), .respEof_r(respEof_r), .respTr0_r(respTr0_r),
    .respTr1_r(respTr1_r), .respRate_r(respRate_r), .cmdActive_r(cmdActive_r));

  tba_reader_model rdr (.core_clk(core_clk), .rxByteValid(rxByteValid),
    .rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxCrcOk(rxCrcOk));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Verdict and hang guard
  task automatic wrapUp();
    if (nErrors == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrapUp

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      nErrors++;
      $display("ERROR %0t timeout", $time);
      wrapUp();
    end
  end

  // ==========================================================================
  // Compare, bus and frame tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic busAddr(input logic [7:0] a, input logic wr);
    @(posedge core_clk);
    haddr  <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask : busAddr

  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    busAddr(a, 1'b1);
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask : busWr

  task automatic busRd(input logic [7:0] a, output logic [31:0] d);
    busAddr(a, 1'b0);
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : busRd

  task automatic frm(input logic [7:0] c, input logic [31:0] id, input logic [7:0] p1,
    input logic [7:0] p2, input logic [7:0] p3, input logic [7:0] p4, input logic crc,
    input int n, input logic resp, input logic act);
    rdr.send({c, id, p1, p2, p3, p4}, crc, n);
    #1;
    chk({31'h0000_0000, respValid_r}, {31'h0000_0000, resp});
    @(posedge core_clk);
    #1;
    chk({31'h0000_0000, respValid_r}, 32'h0000_0000);
    chk({31'h0000_0000, cmdActive_r}, {31'h0000_0000, act});
  endtask : frm

  // ==========================================================================
  // Main sequence
  initial
  begin
    srst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    nErrors = 0;
    cmpCount = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({respSof_r, respEof_r, respByte_r}, 32'h0000_0310);
    chk({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
    busRd(ADDR_CTRL, rd);
    chk(rd, 32'h0000_0001);
    busRd(ADDR_PUPI, rd);
    chk(rd, PUPI_RST);
    busWr(ADDR_PUPI, TAG_ID);
    busRd(ADDR_PUPI, rd);
    chk(rd, TAG_ID);
    busWr(8'h10, 32'hFFFF_FFFF);
    busRd(8'h10, rd);
    chk(rd, 32'h0000_0000);
    frm(8'h1D, 32'h1234_5679, 8'h00, 8'h08, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h08, 8'h01, 8'h00, 1'b0, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h18, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'hA8, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h04, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h09, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h08, 8'h11, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h08, 8'h00, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h08, 8'h01, 8'h01, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1E, TAG_ID, 8'h00, 8'h08, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h08, 8'h01, 8'h00, 1'b1, 10, 1'b0, 1'b0);
    busWr(ADDR_CTRL, 32'h0000_0000);
    frm(8'h1D, TAG_ID, 8'h00, 8'h08, 8'h01, 8'h00, 1'b1, 11, 1'b0, 1'b0);
    busWr(ADDR_CTRL, 32'h0000_0001);
    frm(8'h1D, TAG_ID, 8'hFF, 8'h58, 8'h01, 8'hF0, 1'b1, 11, 1'b1, 1'b1);
    chk({24'h00_0000, respByte_r}, 32'h0000_0010);
    chk({respSof_r, respEof_r, respTr0_r, respTr1_r}, 32'h0000_0030);
    chk({30'h0000_0000, respRate_r}, 32'h0000_0001);
    busRd(ADDR_STATUS, rd);
    chk(rd & 32'h000F_3F1F, 32'h0001_1003);
    busRd(ADDR_PARAM, rd);
    chk(rd, 32'hFF58_01F0);
    frm(8'h1D, TAG_ID, 8'h00, 8'h58, 8'h02, 8'h00, 1'b1, 11, 1'b0, 1'b1);
    busRd(ADDR_STATUS, rd);
    chk(rd & 32'h0000_001F, 32'h0000_0019);
    busWr(ADDR_CTRL, 32'h0000_0003);
    #1;
    chk({31'h0000_0000, cmdActive_r}, 32'h0000_0000);
    for (int r = 0; r < 2; r++)
    begin
      for (int s = 5; s < 9; s++)
      begin
        frm(8'h1D, TAG_ID, 8'h00, {r[1:0], r[1:0], s[3:0]}, 8'h01, 8'h00, 1'b1, 11, 1'b1,
          1'b1);
        chk({30'h0000_0000, respRate_r}, {30'h0000_0000, r[1:0]});
      end
    end
    frm(8'h1D, TAG_ID, 8'h5F, 8'h08, 8'h01, 8'h00, 1'b1, 11, 1'b1, 1'b1);
    chk({respSof_r, respEof_r, respTr0_r, respTr1_r}, 32'h0000_0030);
    busRd(ADDR_STATUS, rd);
    chk(rd & 32'h0000_0F00, 32'h0000_0500);
    wrapUp();
  end
endmodule : type_b_attribute_command_tb
`default_nettype wire
